// ==== logic/scl_pkg.sv ====
// constants and types for the serial configuration load sequencer
// assumes one system clock; the load clock is derived by division from it
// Contract
// - clocks run only while load enable high
// - command output is memory clock divided by four
// - memory enable follows load enable high
// - load enable low stops clock and command
// - device clock is inverted memory clock while loading; both rest low when idle
// - common reset output shared by all devices
// - divided command output initialises serial memory
package scl_pkg;
  // system clock rate and default load clock rate
  localparam int unsigned SYS_CLK_HZ = 125_000_000;
  localparam int unsigned LOAD_CLK_HZ = 10_000;
  // half period of the load clock in system cycles, rounded down, at least one
  localparam int unsigned HALF_CYCLES_CALC = SYS_CLK_HZ / (2 * LOAD_CLK_HZ);
  localparam int unsigned HALF_CYCLES = (HALF_CYCLES_CALC < 1) ? 1 : HALF_CYCLES_CALC;
  // width of the half-period counter
  localparam int unsigned HALF_CNT_W = 16;
  // command divide ratio and its counter width
  localparam int unsigned CMD_DIV = 4;
  localparam int unsigned CMD_CNT_W = 2;
  // reset values
  localparam logic [HALF_CNT_W-1:0] HALF_CNT_RST = 16'h0000;
  localparam logic [CMD_CNT_W-1:0] CMD_CNT_RST = 2'h0;
  localparam logic CLK_RST = 1'b0;
  // sequencer states
  typedef enum logic [1:0] {SCL_IDLE, SCL_LOAD} scl_state_t;
endpackage

// ==== logic/scl_tick.sv ====
// half-period tick generator for the load clock
// assumes synchronous active-low reset and a run enable from the sequencer
`timescale 1ns/1ps
`default_nettype none
module scl_tick #(
  parameter int unsigned HALF = scl_pkg::HALF_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // control
  input wire logic i_run,
  // tick out
  output logic o_tick
);
  import scl_pkg::*;
  localparam logic [HALF_CNT_W-1:0] LAST = HALF_CNT_W'(HALF - 1);
  logic [HALF_CNT_W-1:0] cnt_r;
  logic [HALF_CNT_W-1:0] cnt_nxt;

  // count toward the last cycle, restart whenever not running
  always_comb begin
    if (!i_run || cnt_r == LAST) begin
      cnt_nxt = HALF_CNT_RST;
    end else begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_r <= HALF_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_tick = i_run && (cnt_r == LAST);
endmodule
`default_nettype wire

// ==== logic/scl_top.sv ====
// serial configuration load sequencer top
// assumes load enable is synchronous to the system clock and the reset
// comes from the supply monitor
`timescale 1ns/1ps
`default_nettype none
module scl_top #(
  parameter int unsigned HALF = scl_pkg::HALF_CYCLES
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  // from last configured device
  input wire logic I_LOAD_ENABLE_IN,
  // to serial memory
  output logic O_MEM_CLK,
  output logic O_MEM_CMD,
  output logic O_MEM_SELECT,
  // to configured devices
  output logic O_DEV_CLK,
  output logic O_RESET_OUT_N
);
  import scl_pkg::*;

  // last divider count before the command flips: four load-clock half periods
  localparam logic [CMD_CNT_W-1:0] CMD_LAST = CMD_CNT_W'(CMD_DIV - 1);

  ////////////////////////////////////////////////////////////////////////
  // sequencer state
  scl_state_t state_r;
  scl_state_t state_nxt;
  logic run;
  logic tick;
  logic clk_r;
  logic clk_nxt;
  logic [CMD_CNT_W-1:0] cmd_cnt_r;
  logic [CMD_CNT_W-1:0] cmd_cnt_nxt;
  logic cmd_r;
  logic cmd_nxt;
  logic sel_r;
  logic sel_nxt;
  logic devclk_r;
  logic devclk_nxt;

  // reset lands in idle, so release starts a fresh load when enabled
  always_comb begin
    case (state_r)
      SCL_IDLE: state_nxt = I_LOAD_ENABLE_IN ? SCL_LOAD : SCL_IDLE;
      SCL_LOAD: state_nxt = I_LOAD_ENABLE_IN ? SCL_LOAD : SCL_IDLE;
      default: state_nxt = SCL_IDLE;
    endcase
  end

  assign run = (state_r == SCL_LOAD) && I_LOAD_ENABLE_IN;

  scl_tick #(.HALF(HALF)) u_tick (
    .i_clk(I_SYS_CLK),
    .i_resetn(I_RESETN),
    .i_run(run),
    .o_tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock and command generation
  // the command toggles on every fourth memory clock edge, so its period is
  // four memory clock periods; flipping on every second edge would halve it
  always_comb begin
    clk_nxt = clk_r;
    cmd_cnt_nxt = cmd_cnt_r;
    cmd_nxt = cmd_r;
    if (!run) begin
      clk_nxt = CLK_RST;
      cmd_cnt_nxt = CMD_CNT_RST;
      cmd_nxt = CLK_RST;
    end else if (tick) begin
      clk_nxt = !clk_r;
      cmd_cnt_nxt = cmd_cnt_r + 2'h1;
      // toggle after every fourth half period of the memory clock
      if (cmd_cnt_r == CMD_LAST) begin
        cmd_nxt = !cmd_r;
      end
    end
    // select and device clock are registered copies: glitch-free pins
    sel_nxt = I_LOAD_ENABLE_IN;
    devclk_nxt = run ? !clk_nxt : CLK_RST;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      state_r <= SCL_IDLE;
      clk_r <= CLK_RST;
      cmd_cnt_r <= CMD_CNT_RST;
      cmd_r <= CLK_RST;
      sel_r <= 1'b0;
      devclk_r <= CLK_RST;
    end else begin
      state_r <= state_nxt;
      clk_r <= clk_nxt;
      cmd_cnt_r <= cmd_cnt_nxt;
      cmd_r <= cmd_nxt;
      sel_r <= sel_nxt;
      devclk_r <= devclk_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // divide checker helper
  // counts memory clock edges since the last command change; it only feeds
  // the checks below and costs three flops, traded for a real period check
  // of the command rather than a phase check alone
  logic [2:0] edge_cnt_r;
  logic [2:0] edge_cnt_nxt;

  // cleared whenever the load stops, so every load is measured afresh
  always_comb begin
    edge_cnt_nxt = edge_cnt_r;
    if (!run) begin
      edge_cnt_nxt = 3'h0;
    end else if (clk_nxt != clk_r) begin
      if (cmd_nxt != cmd_r) begin
        edge_cnt_nxt = 3'h0;
      end else begin
        edge_cnt_nxt = edge_cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      edge_cnt_r <= 3'h0;
    end else begin
      edge_cnt_r <= edge_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  // a limitation: the load rate is fixed by the divider, not by a capacitor
  // as on the original pin, so slow memories need a larger half period
  assign O_MEM_CLK = clk_r;
  assign O_MEM_CMD = cmd_r;
  assign O_MEM_SELECT = sel_r;
  assign O_DEV_CLK = devclk_r;
  // the supply-monitor reset is passed straight on so all parts move together
  assign O_RESET_OUT_N = I_RESETN;

  ////////////////////////////////////////////////////////////////////////
  // checks
  mem_clk_idle_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    !I_LOAD_ENABLE_IN |=> !O_MEM_CLK && !O_DEV_CLK)
    else $error("clock ran with load enable low");

  cmd_stop_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    $fell(I_LOAD_ENABLE_IN) |=> !O_MEM_CMD && !O_MEM_CLK)
    else $error("command kept running after enable fell");

  select_follow_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    I_LOAD_ENABLE_IN |=> O_MEM_SELECT)
    else $error("select not high during load");

  select_low_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    !I_LOAD_ENABLE_IN |=> !O_MEM_SELECT)
    else $error("select high without enable");

  dev_clk_inv_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    (run && $past(run)) |-> (O_DEV_CLK == !O_MEM_CLK))
    else $error("device clock not inverse of memory clock");

  cmd_div_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    (run && $changed(O_MEM_CMD) && $past(run)) |-> $rose(O_MEM_CLK) || $fell(O_MEM_CLK))
    else $error("command changed without memory clock edge");

  cmd_phase_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    (run && $changed(O_MEM_CMD) && $past(run)) |-> cmd_cnt_r == CMD_CNT_RST)
    else $error("command toggled at wrong divide phase");

  div_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    !run |=> cmd_cnt_r == CMD_CNT_RST)
    else $error("divider not cleared while idle");

  fresh_load_a: assert property (@(posedge I_SYS_CLK)
    ($rose(I_RESETN) && I_LOAD_ENABLE_IN) |=> state_r == SCL_LOAD)
    else $error("no load started after reset release");

  reset_pass_a: assert property (@(posedge I_SYS_CLK)
    O_RESET_OUT_N == I_RESETN)
    else $error("reset output differs from reset");

  // the command flips only together with a falling memory clock
  cmd_on_fall_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    (run && $past(run) && $changed(O_MEM_CMD)) |-> $fell(O_MEM_CLK))
    else $error("command changed off a falling memory clock");

  // four memory clock edges between command changes: divide by four
  cmd_every_four_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    (run && $past(run) && $changed(O_MEM_CMD)) |-> $past(edge_cnt_r) == 3'h3)
    else $error("command period is not four memory clocks");

  edge_bound_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    edge_cnt_r <= 3'h3)
    else $error("command missed its divide point");

  // the memory clock only moves on a half-period tick
  clk_tick_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    (run && $past(run) && $changed(O_MEM_CLK)) |-> $past(tick))
    else $error("memory clock moved without a tick");

  // a new load always starts low with a cleared divider
  start_phase_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    $rose(run) |-> !O_MEM_CLK && !O_MEM_CMD && cmd_cnt_r == CMD_CNT_RST)
    else $error("load started in a stale phase");

  dev_clk_stop_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    $fell(I_LOAD_ENABLE_IN) |=> !O_DEV_CLK && !O_MEM_SELECT)
    else $error("device clock or select kept after enable fell");

  // during reset every driven output is parked low
  reset_quiet_a: assert property (@(posedge I_SYS_CLK)
    !I_RESETN |=> !O_MEM_CLK && !O_MEM_CMD && !O_MEM_SELECT && !O_DEV_CLK)
    else $error("outputs active during reset");
endmodule
`default_nettype wire

// ==== dv/scl_dev_model.sv ====
// model of the last configured device in the cascade
// assumes the bench pulses i_start and holds i_bits steady during a load
`timescale 1ns/1ps
`default_nettype none
module scl_dev_model (
  // clock and control
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic [3:0] i_bits,
  // from sequencer
  input wire logic i_dev_clk,
  // to sequencer
  output logic o_en
);
  logic [3:0] cnt_r;
  logic dev_q;
  initial begin
    o_en = 1'b0;
    cnt_r = 4'h0;
    dev_q = 1'b0;
  end
  // enable stays high until i_bits device clock rises are seen
  always @(negedge i_clk) begin
    dev_q <= i_dev_clk;
    if (!i_resetn) begin
      cnt_r <= 4'h0; // common reset restarts the device count, enable kept
    end else if (i_start) begin
      o_en <= 1'b1;
      cnt_r <= 4'h0;
    end else if (o_en && i_dev_clk && !dev_q) begin
      if (cnt_r + 4'h1 == i_bits) o_en <= 1'b0;
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== dv/serial_config_load_sequencer_tb_top.sv ====
// self-checking bench for the load sequencer with a device model
// assumes a half period of 3 system cycles for the load clock
`timescale 1ns/1ps
`default_nettype none
module serial_config_load_sequencer_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  logic [3:0] bits = 4'h2;
  logic pm = 1'b0;
  logic pc = 1'b0;
  logic psel = 1'b0;
  wire logic en, mclk, mcmd, msel, dclk, rout;
  int err_total = 0;
  int n_tests = 0;
  int nr = 0;
  int nc = 0;
  int exq[$];
  always #4 clk = ~clk;
  scl_top #(.HALF(3)) u_scl_top (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_LOAD_ENABLE_IN(en),
    .O_MEM_CLK(mclk), .O_MEM_CMD(mcmd), .O_MEM_SELECT(msel), .O_DEV_CLK(dclk),
    .O_RESET_OUT_N(rout));
  scl_dev_model u_scl_dev_model (.i_clk(clk), .i_resetn(rout), .i_start(start), .i_bits(bits),
    .i_dev_clk(dclk), .o_en(en));
  // one comparison of a byte-wide result
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_tests++;
    if (got !== ex) begin
      err_total++;
      $display("unexpected %s exp %0h got %0h", nm, ex, got);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bounded wait on the memory select level
  task automatic wait_sel(input logic v);
    int k;
    for (k = 0; k < 2000 && msel !== v; k++) @(negedge clk);
    if (k == 2000) begin
      err_total++;
      results();
    end
  endtask
  // watcher: counts edges, pops the two oldest notes when a load ends
  always @(negedge clk) begin
    pm <= mclk;
    pc <= mcmd;
    psel <= msel;
    if (mclk && !pm) nr++;
    if (mcmd && !pc) nc++;
    if (!msel && psel && rout) begin
      chk("clock rises", 8'(exq.pop_front()), nr[7:0]);
      chk("command rises", 8'(exq.pop_front()), nc[7:0]);
      nr = 0;
      nc = 0;
    end
    // a reset in mid-load restarts the count along with the devices
    if (!rout) begin
      nr = 0;
      nc = 0;
    end
    if (!msel) chk("idle outputs", 8'h00, {5'h00, mclk, mcmd, dclk});
    if (mclk) chk("device phase", 8'h00, {7'h00, dclk});
    chk("select", {7'h00, en && rstn}, {7'h00, msel});
    chk("reset out", {7'h00, rstn}, {7'h00, rout});
  end
  // five loads: the first of two device clocks straight after reset, the rest of random length
  initial begin
    int t;
    void'($urandom(83));
    repeat (6) @(negedge clk);
    rstn <= 1'b1;
    for (t = 0; t < 5; t++) begin
      bits <= (t == 0) ? 4'h2 : 4'h2 + 4'($urandom_range(7));
      @(negedge clk);
      exq.push_back(int'(bits) - 1);
      exq.push_back((int'(bits) + 1) / 4);
      start <= 1'b1;
      @(negedge clk);
      start <= 1'b0;
      wait_sel(1'b1);
      wait_sel(1'b0);
      repeat (10) @(negedge clk);
      $display("load %0d of %0d device clocks done", t, bits);
    end
    // supply dip in mid-load: release with enable high must start afresh
    bits <= 4'h9;
    @(negedge clk);
    exq.push_back(int'(bits) - 1);
    exq.push_back((int'(bits) + 1) / 4);
    start <= 1'b1;
    @(negedge clk);
    start <= 1'b0;
    wait_sel(1'b1);
    repeat (9) @(negedge clk);
    rstn <= 1'b0;
    repeat (3) @(negedge clk);
    rstn <= 1'b1;
    wait_sel(1'b1);
    wait_sel(1'b0);
    repeat (10) @(negedge clk);
    $display("reload after reset of %0d device clocks done", bits);
    results();
  end
endmodule
`default_nettype wire
